// File: afr_pkg.sv
package afr_pkg;
   // Register offsets on the serial register port
   localparam logic [6:0] ADDR_POWER = 7'h6c;
   localparam logic [6:0] ADDR_LEVEL_HI = 7'h72;
   localparam logic [6:0] ADDR_LEVEL_LO = 7'h73;
   localparam logic [6:0] ADDR_DATA = 7'h74;
   localparam logic [6:0] ADDR_IDENT = 7'h75;
   localparam logic [6:0] ADDR_X_HI = 7'h77;
   localparam logic [6:0] ADDR_X_LO = 7'h78;
   localparam logic [6:0] ADDR_Y_HI = 7'h7a;
   localparam logic [6:0] ADDR_Y_LO = 7'h7b;
   localparam logic [6:0] ADDR_Z_HI = 7'h7d;
   localparam logic [6:0] ADDR_Z_LO = 7'h7e;
   // Field positions of the power control register
   localparam int BIT_LP_FIFO = 7;
   localparam int BIT_STBY_X = 5;
   localparam int BIT_STBY_Y = 4;
   localparam int BIT_STBY_Z = 3;
   // Buffer geometry and markers
   localparam int FIFO_DEPTH = 512;
   localparam int PTR_W = 9;
   localparam int LEVEL_W = 13;
   localparam int LEVEL_HI_W = 5;
   localparam logic [7:0] EMPTY_MARK = 8'hff;
   localparam logic [7:0] CLAMP_MARK = 8'hfe;
   // Sensor data registers 59 through 72
   localparam int SENSOR_BYTES = 14;
   localparam logic [3:0] LAST_IDX = 4'hd;
   // Offset fields
   localparam int OFFS_W = 15;
   localparam logic [OFFS_W-1:0] OFFS_RESET = 15'h0000;
   localparam logic [7:0] POWER_RESET = 8'h00;
   localparam logic [6:0] BUS_ADDR_BASE = 7'h68;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_STORE = 1'b1
   } afr_state_t;
endpackage

// File: afr_fifo_store.sv
`timescale 1ns/1ps
`default_nettype none
module afr_fifo_store (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic [7:0] push_data,
   input wire logic pop,
   input wire logic keep_old,
   output logic [7:0] head_data,
   output logic [afr_pkg::LEVEL_W-1:0] level,
   output logic full,
   output logic empty,
   output logic overflow
);
   logic [7:0] mem_r [afr_pkg::FIFO_DEPTH];
   logic [afr_pkg::PTR_W-1:0] wr_ptr_r;
   logic [afr_pkg::PTR_W-1:0] rd_ptr_r;
   logic [afr_pkg::PTR_W:0] count_r;
   logic do_pop;
   logic do_wr;
   logic adv_rd;

   // Flags and the overwrite decision
   assign empty = (count_r == '0);
   assign full = (count_r == (afr_pkg::PTR_W+1)'(afr_pkg::FIFO_DEPTH));
   assign do_pop = pop & ~empty;
   assign overflow = push & full & ~do_pop;
   assign do_wr = push & (~full | do_pop | ~keep_old);
   assign adv_rd = do_pop | (overflow & ~keep_old); // Oldest byte dropped
   assign head_data = mem_r[rd_ptr_r];
   assign level = afr_pkg::LEVEL_W'(count_r);

   // Storage write, indexed by the write pointer
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem_r[wr_ptr_r] <= push_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (adv_rd) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (afr_pkg::PTR_W+1)'(do_wr) - (afr_pkg::PTR_W+1)'(adv_rd);
      end
   end

   a_keep_mode: assert property (@(posedge clk) disable iff (!rst_n)
      overflow && keep_old |=> $stable(wr_ptr_r) && $stable(count_r))
      else $error("Keep mode overwrote stored data");
   a_drop_oldest: assert property (@(posedge clk) disable iff (!rst_n)
      overflow && !keep_old |=> full && rd_ptr_r == $past(rd_ptr_r) + 1'b1)
      else $error("Overwrite mode did not drop the oldest byte");
endmodule
`default_nettype wire

// File: afr_regs_top.sv
`timescale 1ns/1ps
`default_nettype none
module afr_regs_top #(
   parameter logic [7:0] DEVICE_ID_VALUE = 8'h5a // Arbitrary identifier value
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [6:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic address_select_pin,
   output logic [6:0] bus_address,
   input wire logic sample_tick,
   input wire logic [afr_pkg::SENSOR_BYTES*8-1:0] sensor_bytes,
   input wire logic [afr_pkg::SENSOR_BYTES-1:0] source_enable,
   input wire logic fifo_enable,
   input wire logic fifo_keep_mode,
   input wire logic cycle_mode,
   input wire logic sleep_mode,
   input wire logic standby_mode,
   input wire logic overflow_flag_clear,
   output logic buffer_overflow_flag,
   output logic buffer_in_low_power_enable,
   output logic x_axis_standby,
   output logic y_axis_standby,
   output logic z_axis_standby,
   output logic accel_awake,
   output logic [afr_pkg::OFFS_W-1:0] x_offset_value,
   output logic [afr_pkg::OFFS_W-1:0] y_offset_value,
   output logic [afr_pkg::OFFS_W-1:0] z_offset_value
);
   afr_pkg::afr_state_t state_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rvalid_r;
   logic sel_meta_r;
   logic sel_sync_r;
   logic [6:0] bus_addr_r;
   logic lp_en_r;
   logic [2:0] stby_r;
   logic ovf_flag_r;
   logic awake_r;
   logic [afr_pkg::OFFS_W-1:0] x_offs_r;
   logic [afr_pkg::OFFS_W-1:0] y_offs_r;
   logic [afr_pkg::OFFS_W-1:0] z_offs_r;
   logic [2:0] cal_bit_r;
   logic [afr_pkg::LEVEL_W-1:0] level_snap_r;
   logic [7:0] shadow_r [afr_pkg::SENSOR_BYTES];
   logic [afr_pkg::SENSOR_BYTES-1:0] shadow_en_r;
   logic [3:0] idx_r;
   logic [3:0] last_pushed_r;
   logic have_pushed_r;
   logic lp_mode;
   logic all_stby;
   logic store_ok;
   logic host_push;
   logic host_pop;
   logic samp_push;
   logic samp_hold;
   logic fifo_push;
   logic [7:0] push_raw;
   logic [7:0] push_data;
   logic [7:0] head_data;
   logic [afr_pkg::LEVEL_W-1:0] level;
   logic fifo_full;
   logic fifo_empty;
   logic fifo_ovf;

   // Host access decode for the data port
   assign host_push = reg_wr & (reg_addr == afr_pkg::ADDR_DATA);
   assign host_pop = reg_rd & (reg_addr == afr_pkg::ADDR_DATA);

   // Cycling mode: sleep between single samples
   assign lp_mode = cycle_mode & ~sleep_mode & ~standby_mode;
   assign all_stby = &stby_r;
   // In cycling mode the buffer needs its own enable, and no axis means no sample
   assign store_ok = fifo_enable & (~lp_mode | (lp_en_r & ~all_stby));

   // Sampler push; a host write in the same cycle wins and the sampler waits
   assign samp_hold = host_push;
   assign samp_push = (state_r == afr_pkg::ST_STORE) & shadow_en_r[idx_r] & ~samp_hold;
   assign fifo_push = samp_push | host_push;
   assign push_raw = host_push ? reg_wdata : shadow_r[idx_r];
   // The empty marker is reserved, so a full-scale byte is pulled down by one
   assign push_data = (push_raw == afr_pkg::EMPTY_MARK) ? afr_pkg::CLAMP_MARK : push_raw;

   afr_fifo_store u_store (
      .clk(clk),
      .rst_n(rst_n),
      .push(fifo_push),
      .push_data(push_data),
      .pop(host_pop),
      .keep_old(fifo_keep_mode),
      .head_data(head_data),
      .level(level),
      .full(fifo_full),
      .empty(fifo_empty),
      .overflow(fifo_ovf)
   );

   // Select pin comes from outside, two flops before use
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sel_meta_r <= 1'b0;
         sel_sync_r <= 1'b0;
      end else begin
         sel_meta_r <= address_select_pin;
         sel_sync_r <= sel_meta_r;
      end
   end

   // Bus address follows the pin only; the identifier never does
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bus_addr_r <= afr_pkg::BUS_ADDR_BASE;
      end else begin
         bus_addr_r <= afr_pkg::BUS_ADDR_BASE | {6'h00, sel_sync_r};
      end
   end

   // Power control register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lp_en_r <= afr_pkg::POWER_RESET[afr_pkg::BIT_LP_FIFO];
         stby_r <= 3'h0;
      end else if (reg_wr && reg_addr == afr_pkg::ADDR_POWER) begin
         lp_en_r <= reg_wdata[afr_pkg::BIT_LP_FIFO];
         stby_r <= {reg_wdata[afr_pkg::BIT_STBY_X], reg_wdata[afr_pkg::BIT_STBY_Y],
                    reg_wdata[afr_pkg::BIT_STBY_Z]};
      end
   end

   // Offset registers, held as whole 15-bit values; scaling is fixed per step
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         x_offs_r <= afr_pkg::OFFS_RESET;
         y_offs_r <= afr_pkg::OFFS_RESET;
         z_offs_r <= afr_pkg::OFFS_RESET;
         cal_bit_r <= 3'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            afr_pkg::ADDR_X_HI: begin
               x_offs_r[14:7] <= reg_wdata;
            end
            afr_pkg::ADDR_X_LO: begin
               x_offs_r[6:0] <= reg_wdata[7:1];
               cal_bit_r[0] <= reg_wdata[0]; // Host must write back the old value
            end
            afr_pkg::ADDR_Y_HI: begin
               y_offs_r[14:7] <= reg_wdata;
            end
            afr_pkg::ADDR_Y_LO: begin
               y_offs_r[6:0] <= reg_wdata[7:1];
               cal_bit_r[1] <= reg_wdata[0];
            end
            afr_pkg::ADDR_Z_HI: begin
               z_offs_r[14:7] <= reg_wdata;
            end
            afr_pkg::ADDR_Z_LO: begin
               z_offs_r[6:0] <= reg_wdata[7:1];
               cal_bit_r[2] <= reg_wdata[0];
            end
            default: begin
            end
         endcase
      end
   end

   // Count snapshot: only a high-byte read refreshes both halves
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         level_snap_r <= '0;
      end else if (reg_rd && reg_addr == afr_pkg::ADDR_LEVEL_HI) begin
         level_snap_r <= level;
      end
   end

   // Read mux; the high byte returns the value it is latching
   always_comb begin
      rdata_nxt = afr_pkg::ZERO_BYTE;
      case (reg_addr)
         afr_pkg::ADDR_POWER: begin
            rdata_nxt = {lp_en_r, 1'b0, stby_r, 3'h0};
         end
         afr_pkg::ADDR_LEVEL_HI: begin
            rdata_nxt = {3'h0, level[afr_pkg::LEVEL_W-1:8]};
         end
         afr_pkg::ADDR_LEVEL_LO: begin
            rdata_nxt = level_snap_r[7:0];
         end
         afr_pkg::ADDR_DATA: begin
            rdata_nxt = fifo_empty ? afr_pkg::EMPTY_MARK : head_data;
         end
         afr_pkg::ADDR_IDENT: begin
            rdata_nxt = DEVICE_ID_VALUE;
         end
         afr_pkg::ADDR_X_HI: begin
            rdata_nxt = x_offs_r[14:7];
         end
         afr_pkg::ADDR_X_LO: begin
            rdata_nxt = {x_offs_r[6:0], cal_bit_r[0]};
         end
         afr_pkg::ADDR_Y_HI: begin
            rdata_nxt = y_offs_r[14:7];
         end
         afr_pkg::ADDR_Y_LO: begin
            rdata_nxt = {y_offs_r[6:0], cal_bit_r[1]};
         end
         afr_pkg::ADDR_Z_HI: begin
            rdata_nxt = z_offs_r[14:7];
         end
         afr_pkg::ADDR_Z_LO: begin
            rdata_nxt = {z_offs_r[6:0], cal_bit_r[2]};
         end
         default: begin
            rdata_nxt = afr_pkg::ZERO_BYTE;
         end
      endcase
   end

   // Read data register, answered one cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= afr_pkg::ZERO_BYTE;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd;
         if (reg_rd) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // Sample capture and the ascending store walk
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= afr_pkg::ST_IDLE;
         idx_r <= 4'h0;
         shadow_en_r <= '0;
      end else begin
         case (state_r)
            afr_pkg::ST_IDLE: begin
               if (sample_tick && store_ok) begin
                  state_r <= afr_pkg::ST_STORE;
                  idx_r <= 4'h0;
                  shadow_en_r <= source_enable;
               end
            end
            afr_pkg::ST_STORE: begin
               // Ticks arriving mid-walk are dropped; the walk is 14 cycles plus one per host data write that stalls it
               if (!(shadow_en_r[idx_r] && samp_hold)) begin
                  if (idx_r == afr_pkg::LAST_IDX) begin
                     state_r <= afr_pkg::ST_IDLE;
                  end else begin
                     idx_r <= idx_r + 4'h1;
                  end
               end
            end
            default: begin
               state_r <= afr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Snapshot of registers 59..72 taken at the tick
   genvar gi;
   generate
      for (gi = 0; gi < afr_pkg::SENSOR_BYTES; gi++) begin : g_shadow
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               shadow_r[gi] <= afr_pkg::ZERO_BYTE;
            end else if (state_r == afr_pkg::ST_IDLE && sample_tick && store_ok) begin
               shadow_r[gi] <= sensor_bytes[gi*8 +: 8];
            end
         end
      end
   endgenerate

   // Order tracking for the walk, read by checks only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         last_pushed_r <= 4'h0;
         have_pushed_r <= 1'b0;
      end else if (state_r == afr_pkg::ST_IDLE) begin
         have_pushed_r <= 1'b0;
      end else if (samp_push) begin
         last_pushed_r <= idx_r;
         have_pushed_r <= 1'b1;
      end
   end

   // Sticky overflow flag; a new overflow beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ovf_flag_r <= 1'b0;
      end else if (fifo_ovf) begin
         ovf_flag_r <= 1'b1;
      end else if (overflow_flag_clear) begin
         ovf_flag_r <= 1'b0;
      end
   end

   // Awake indication: in cycling mode only while a sample is taken
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         awake_r <= 1'b0;
      end else if (lp_mode) begin
         awake_r <= (state_r == afr_pkg::ST_STORE) | (sample_tick & store_ok);
      end else begin
         awake_r <= ~sleep_mode & ~standby_mode;
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign bus_address = bus_addr_r;
   assign buffer_overflow_flag = ovf_flag_r;
   assign buffer_in_low_power_enable = lp_en_r;
   assign x_axis_standby = stby_r[2];
   assign y_axis_standby = stby_r[1];
   assign z_axis_standby = stby_r[0];
   assign accel_awake = awake_r;
   // Offset value, 0.98 mg per step over +/-16 g, whatever range is selected
   assign x_offset_value = x_offs_r;
   assign y_offset_value = y_offs_r;
   assign z_offset_value = z_offs_r;

   a_lp_gate: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == afr_pkg::ST_IDLE && sample_tick && lp_mode && !lp_en_r
      |=> state_r == afr_pkg::ST_IDLE)
      else $error("Buffer filled in cycling mode while disabled");
   a_standby_bits: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == afr_pkg::ADDR_POWER
      |=> x_axis_standby == $past(reg_wdata[5]) && z_axis_standby == $past(reg_wdata[3]))
      else $error("Axis standby did not follow the write");
   a_count_snap: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == afr_pkg::ADDR_LEVEL_HI
      |=> level_snap_r == $past(level) && reg_rdata == {3'h0, level_snap_r[12:8]})
      else $error("Count halves not captured together");
   a_low_stable: assert property (@(posedge clk) disable iff (!rst_n)
      !(reg_rd && reg_addr == afr_pkg::ADDR_LEVEL_HI) |=> $stable(level_snap_r))
      else $error("Low count changed without a high read");
   a_store_order: assert property (@(posedge clk) disable iff (!rst_n)
      samp_push && have_pushed_r |-> idx_r > last_pushed_r)
      else $error("Sensor bytes stored out of order");
   a_skip_off: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == afr_pkg::ST_STORE && !shadow_en_r[idx_r] |-> !samp_push)
      else $error("Disabled source was stored");
   a_ovf_flag: assert property (@(posedge clk) disable iff (!rst_n)
      fifo_ovf |=> buffer_overflow_flag [*2])
      else $error("Overflow did not set a sticky flag");
   a_empty_mark: assert property (@(posedge clk) disable iff (!rst_n)
      host_pop && fifo_empty |=> reg_rvalid && reg_rdata == 8'hff)
      else $error("Empty read did not return the marker");
   a_no_marker: assert property (@(posedge clk) disable iff (!rst_n)
      fifo_push |-> push_data != 8'hff)
      else $error("Marker value entered the buffer");
   a_ident: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == afr_pkg::ADDR_IDENT |=> reg_rdata == DEVICE_ID_VALUE)
      else $error("Identity read returned a wrong value");
   a_bus_addr: assert property (@(posedge clk) disable iff (!rst_n)
      address_select_pin [*4] |=> bus_address == 7'h69)
      else $error("Bus address ignores the select pin");
   a_pop_level: assert property (@(posedge clk) disable iff (!rst_n)
      host_pop && !fifo_empty && !fifo_push |=> level == $past(level) - 13'h0001)
      else $error("Data read did not remove one byte");
endmodule
`default_nettype wire

// File: afr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port: one strobe per access, changed only at the falling edge
module afr_host_model (
   input wire logic clk,
   output logic [6:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   // Quiet bus at time zero
   initial begin
      reg_addr = 7'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   // Released lines carry the inverse of the last value so stale data never looks right
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // Answer is due one cycle after the strobe; a missing valid yields unknown data
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
      reg_rd = 1'b0;
      reg_addr = ~a;
   endtask
   // Low offset writes read first so the calibration bit survives
   task automatic rmw_low(input logic [6:0] a, input logic [6:0] v);
      logic [7:0] cur;
      rd(a, cur);
      wr(a, {v, cur[0]});
   endtask
endmodule
`default_nettype wire

// File: tb_afr_regs_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_afr_regs_top;
   localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value
   logic clk, rst_n, reg_rd, reg_wr, reg_rvalid, address_select_pin, sample_tick;
   logic [6:0] reg_addr, bus_address;
   logic [7:0] reg_wdata, reg_rdata;
   logic [afr_pkg::SENSOR_BYTES*8-1:0] sensor_bytes;
   logic [afr_pkg::SENSOR_BYTES-1:0] source_enable;
   logic fifo_enable, fifo_keep_mode, cycle_mode, sleep_mode, standby_mode, overflow_flag_clear;
   logic buffer_overflow_flag, buffer_in_low_power_enable, x_axis_standby, y_axis_standby, z_axis_standby;
   logic accel_awake;
   logic [afr_pkg::OFFS_W-1:0] x_offset_value, y_offset_value, z_offset_value;
   logic [7:0] q[$];
   int n_fail = 0;
   int checks_done = 0;

   afr_regs_top #(.DEVICE_ID_VALUE(ID)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .address_select_pin(address_select_pin), .bus_address(bus_address), .sample_tick(sample_tick),
      .sensor_bytes(sensor_bytes), .source_enable(source_enable), .fifo_enable(fifo_enable),
      .fifo_keep_mode(fifo_keep_mode), .cycle_mode(cycle_mode), .sleep_mode(sleep_mode),
      .standby_mode(standby_mode), .overflow_flag_clear(overflow_flag_clear),
      .buffer_overflow_flag(buffer_overflow_flag), .buffer_in_low_power_enable(buffer_in_low_power_enable),
      .x_axis_standby(x_axis_standby), .y_axis_standby(y_axis_standby), .z_axis_standby(z_axis_standby),
      .accel_awake(accel_awake), .x_offset_value(x_offset_value), .y_offset_value(y_offset_value),
      .z_offset_value(z_offset_value));
   afr_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // Free-running 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Host push mirrored in the expected queue, including the overflow policy
   task automatic push(input logic [7:0] d);
      host.wr(afr_pkg::ADDR_DATA, d);
      if (q.size() == afr_pkg::FIFO_DEPTH && fifo_keep_mode) return;
      if (q.size() == afr_pkg::FIFO_DEPTH) void'(q.pop_front());
      q.push_back(d == 8'hff ? 8'hfe : d);
   endtask
   task automatic pop_chk();
      logic [7:0] d;
      host.rd(afr_pkg::ADDR_DATA, d);
      chk("data port", (q.size() != 0) ? q.pop_front() : 8'hff, d);
   endtask
   task automatic count_chk(input int n);
      logic [7:0] h, l;
      host.rd(afr_pkg::ADDR_LEVEL_HI, h);
      host.rd(afr_pkg::ADDR_LEVEL_LO, l);
      chk("level", 16'(n), {h, l});
   endtask
   // Fixed wait covers the 14-cycle store walk with margin
   task automatic tick();
      @(negedge clk);
      sample_tick = 1'b1;
      @(negedge clk);
      sample_tick = 1'b0;
      repeat (16) @(negedge clk);
   endtask
   task automatic t_reset();
      logic [7:0] d;
      host.rd(afr_pkg::ADDR_POWER, d);
      chk("power reset", 8'h00, d);
      host.rd(afr_pkg::ADDR_IDENT, d);
      chk("identity", ID, d);
      host.rd(7'h10, d);
      chk("unmapped", 8'h00, d);
      chk("bus address low", 7'h68, bus_address);
      chk("awake", 1'b1, accel_awake);
      $display("test reset done");
   endtask
   task automatic t_power();
      logic [7:0] d;
      host.wr(afr_pkg::ADDR_POWER, 8'hff);
      host.rd(afr_pkg::ADDR_POWER, d);
      chk("power readback", 8'hb8, d);
      chk("power fields", 4'hf, {buffer_in_low_power_enable, x_axis_standby, y_axis_standby, z_axis_standby});
      host.wr(afr_pkg::ADDR_POWER, 8'h10);
      chk("y standby only", 4'h2, {buffer_in_low_power_enable, x_axis_standby, y_axis_standby, z_axis_standby});
      host.wr(afr_pkg::ADDR_IDENT, 8'h00);
      address_select_pin = 1'b1;
      repeat (4) @(negedge clk);
      chk("bus address high", 7'h69, bus_address);
      host.rd(afr_pkg::ADDR_IDENT, d);
      chk("identity kept", ID, d);
      $display("test power done");
   endtask
   task automatic t_offsets();
      logic [6:0] a;
      logic [7:0] d;
      for (int i = 0; i < 3; i++) begin
         a = afr_pkg::ADDR_X_HI + 7'(3 * i);
         host.wr(a, 8'hc3);
         host.wr(a + 7'h01, 8'h35);
         host.rmw_low(a + 7'h01, 7'h4b);
         host.rd(a + 7'h01, d);
         chk("offset low", 8'h97, d);
      end
      chk("x offset", {8'hc3, 7'h4b}, x_offset_value);
      chk("y offset", {8'hc3, 7'h4b}, y_offset_value);
      chk("z offset", {8'hc3, 7'h4b}, z_offset_value);
      $display("test offsets done");
   endtask
   task automatic t_walk();
      logic [7:0] d;
      for (int i = 0; i < 14; i++) sensor_bytes[8*i +: 8] = 8'(i + 1);
      sensor_bytes[23:16] = 8'hff;
      source_enable = 14'h3ffd;
      fifo_enable = 1'b1;
      cycle_mode = 1'b1;
      tick();
      count_chk(0);
      chk("asleep in cycling", 1'b0, accel_awake);
      // Cycling mode with the low-power buffer enable set must store a full walk
      host.wr(afr_pkg::ADDR_POWER, 8'h80);
      tick();
      cycle_mode = 1'b0;
      tick();
      repeat (2) for (int i = 0; i < 14; i++) if (i != 1) q.push_back(i == 2 ? 8'hfe : 8'(i + 1));
      count_chk(26);
      pop_chk();
      host.rd(afr_pkg::ADDR_LEVEL_LO, d);
      chk("low stays latched", 8'h1a, d);
      count_chk(25);
      while (q.size() != 0) pop_chk();
      pop_chk();
      count_chk(0);
      $display("test walk done");
   endtask
   task automatic t_overflow();
      for (int i = 0; i < afr_pkg::FIFO_DEPTH; i++) push(8'(i));
      count_chk(afr_pkg::FIFO_DEPTH);
      chk("flag idle", 1'b0, buffer_overflow_flag);
      push(8'haa);
      repeat (2) @(negedge clk);
      chk("overflow flag", 1'b1, buffer_overflow_flag);
      count_chk(afr_pkg::FIFO_DEPTH);
      pop_chk();
      overflow_flag_clear = 1'b1;
      @(negedge clk);
      overflow_flag_clear = 1'b0;
      @(negedge clk);
      chk("flag cleared", 1'b0, buffer_overflow_flag);
      push(8'h55);
      fifo_keep_mode = 1'b1;
      push(8'hbb);
      repeat (2) @(negedge clk);
      chk("overflow flag keep", 1'b1, buffer_overflow_flag);
      while (q.size() != 0) pop_chk();
      pop_chk();
      $display("test overflow done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Hang guard, well above the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      summarize();
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      address_select_pin = 1'b0;
      sample_tick = 1'b0;
      sensor_bytes = '0;
      source_enable = '0;
      fifo_enable = 1'b0;
      fifo_keep_mode = 1'b0;
      cycle_mode = 1'b0;
      sleep_mode = 1'b0;
      standby_mode = 1'b0;
      overflow_flag_clear = 1'b0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_power();
      t_offsets();
      t_walk();
      t_overflow();
      summarize();
   end
endmodule
`default_nettype wire
